//--- testbench/acc_far_model.sv
// Purpose: analog comparator and external capture RAM
// Assumes: input levels given per channel as 12-bit codes
// Notes:   RAM stalls at random, logs the first eight writes
`timescale 1ns/1ps
module acc_far_model (
    input wire         clk_in, rst_n_in, dma_wr_in,
    input wire [3:0]   chan_in,
    input wire [11:0]  dac_in,
    input wire [107:0] vin_in,
    input wire [23:0]  addr_in,
    input wire [15:0]  data_in,
    output wire        cmp_out,
    output reg         ready_out
);
    reg [7:0]  lfsr;
    reg [23:0] addr_log [0:7];
    reg [15:0] data_log [0:7];
    int        n_wr;
    // Trial bit kept while the trial code does not pass the input
    assign cmp_out = dac_in <= vin_in[chan_in*12 +: 12];
    ////////////////////////////////////////////////////////////////
    // RAM write port; ready wanders so slow answers get exercised
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            lfsr      <= 8'h5b;
            ready_out <= 1'b0;
            n_wr      <= 0;
        end else begin
            lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            ready_out <= lfsr[0] | lfsr[1];
            if (dma_wr_in && ready_out) begin
                if (n_wr < 8) begin
                    addr_log[n_wr] <= addr_in;
                    data_log[n_wr] <= data_in;
                end
                n_wr <= n_wr + 1;
            end
        end
    end
endmodule // acc_far_model

//--- testbench/acc_sva.sv
// Purpose: port-level checks for the converter control block
// Assumes: single clock, synchronous active-low reset
// Notes:   bound to acc_top, watches ports only
`timescale 1ns/1ps
module acc_sva (
    input wire        core_clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in,
    input wire        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out,
    input wire        s_axi_arready_out, s_axi_bvalid_out, s_axi_rvalid_out, track_hold_out,
    input wire        dma_wr_out, dma_ready_in,
    input wire [31:0] s_axi_rdata_out,
    input wire [3:0]  channel_select_out,
    input wire [11:0] factory_offset_in, factory_gain_in, cal_offset_out, cal_gain_out,
    input wire [23:0] dma_addr_out,
    input wire [15:0] dma_data_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // A conversion keeps the sample held for the first eight cycles after hold rises
    sequence s_hold_run;
        track_hold_out [*8];
    endsequence
    ////////////////////////////////////////////////////////////////
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data not held");
    write_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while response pending");
    read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken while data pending");
    bresp_time_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        && s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out) else $error("write response late");
    rdata_time_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data late");
    dma_hold_a: assert property (dma_wr_out && !dma_ready_in |=> dma_wr_out && $stable(dma_addr_out)
        && $stable(dma_data_out)) else $error("capture write not held");
    chan_range_a: assert property (channel_select_out <= 4'h8)
        else $error("channel select out of range");
    hold_len_a: assert property ($rose(track_hold_out) |-> s_hold_run)
        else $error("hold released too soon");
    cal_load_a: assert property ($rose(rst_n_in) |-> ##[0:2] (cal_offset_out == factory_offset_in
        && cal_gain_out == factory_gain_in)) else $error("factory calibration not loaded");
endmodule // acc_sva
bind acc_top acc_sva u_sva (.core_clk_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_wvalid_in, .s_axi_bready_in,
    .s_axi_arvalid_in, .s_axi_rready_in, .s_axi_awready_out, .s_axi_wready_out, .s_axi_arready_out,
    .s_axi_bvalid_out, .s_axi_rvalid_out, .track_hold_out, .dma_wr_out, .dma_ready_in, .s_axi_rdata_out,
    .channel_select_out, .factory_offset_in, .factory_gain_in, .cal_offset_out, .cal_gain_out,
    .dma_addr_out, .dma_data_out);

//--- testbench/acc_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: 25 MHz clock, register bus driven as AXI4-Lite master
// Notes:   random levels from a fixed-seed xorshift
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_tb_top;
    reg         core_clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    reg         s_axi_rready_in, convert_start_pin_n_in, timer2_overflow_in;
    reg  [3:0]  s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
    reg  [31:0] s_axi_wdata_in, seed, rd, rnd;
    reg  [11:0] factory_offset_in, factory_gain_in;
    reg  [107:0] vin;
    reg  [1:0]  resp;
    wire        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire        track_hold_out, dma_wr_out, dma_ready_in, comparator_in, irq_out;
    wire [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire [3:0]  channel_select_out;
    wire [11:0] dac_code_out, cal_offset_out, cal_gain_out;
    wire [23:0] dma_addr_out;
    wire [15:0] dma_data_out;
    int         n_fail, comparisons, i;
    acc_top dut (.core_clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
        .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .convert_start_pin_n_in,
        .timer2_overflow_in, .factory_offset_in, .factory_gain_in, .comparator_in, .channel_select_out,
        .track_hold_out, .dac_code_out, .cal_offset_out, .cal_gain_out, .dma_addr_out, .dma_data_out,
        .dma_wr_out, .dma_ready_in, .irq_out);
    acc_far_model far (.clk_in(core_clk_in), .rst_n_in(rst_n_in), .dma_wr_in(dma_wr_out),
        .chan_in(channel_select_out), .dac_in(dac_code_out), .vin_in(vin), .addr_in(dma_addr_out),
        .data_in(dma_data_out), .cmp_out(comparator_in), .ready_out(dma_ready_in));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Captured word carries the channel above the result
    function automatic logic [15:0] exp_word(input logic [3:0] ch);
        return {ch, vin[ch*12 +: 12]};
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test();
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Address and data offered together, each released once taken at a rising edge
    task axw(input logic [3:0] a, input logic [31:0] d);
        bit ta, tw;
        ta = 0;
        tw = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        do begin
            @(posedge core_clk_in);
            if (!ta && s_axi_awready_out === 1'b1) begin
                ta = 1;
                s_axi_awvalid_in <= 0;
            end
            if (!tw && s_axi_wready_out === 1'b1) begin
                tw = 1;
                s_axi_wvalid_in <= 0;
            end
        end while (!(ta && tw));
        // Late bready lets the response be seen waiting
        @(posedge core_clk_in);
        s_axi_bready_in <= 1;
        do @(posedge core_clk_in); while (s_axi_bvalid_out !== 1'b1);
        resp = s_axi_bresp_out;
        s_axi_bready_in <= 0;
    endtask
    task axr(input logic [3:0] a);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        do @(posedge core_clk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 0;
        // Late rready lets the data be seen waiting
        @(posedge core_clk_in);
        s_axi_rready_in <= 1;
        do @(posedge core_clk_in); while (s_axi_rvalid_out !== 1'b1);
        rd = s_axi_rdata_out;
        resp = s_axi_rresp_out;
        s_axi_rready_in <= 0;
    endtask
    task wait_irq(input int n);
        for (i = 0; i < n && irq_out !== 1'b1; i++) @(posedge core_clk_in);
    endtask
    // Pin pulses low, timer pulses high, then an idle gap
    task pulse(input bit pin, input bit on);
        if (pin) convert_start_pin_n_in <= 0; else timer2_overflow_in <= 1;
        repeat (3) @(posedge core_clk_in);
        convert_start_pin_n_in <= 1;
        timer2_overflow_in <= 0;
        wait_irq(on ? 400 : 300);
        chk("trigger done", irq_out, on);
        axr(`ACC_CON2_OFS);
    endtask
    initial begin
        core_clk_in = 0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        n_fail++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, timer2_overflow_in} = 0;
        {rst_n_in, n_fail, comparisons} = 0;
        convert_start_pin_n_in = 1;
        s_axi_wstrb_in = 4'hf;
        seed = 32'h0001_1528;
        rnd = xs();
        factory_offset_in = rnd[11:0];
        factory_gain_in = rnd[23:12];
        for (i = 0; i < 9; i++) begin
            rnd = xs();
            vin[i*12 +: 12] = rnd[11:0];
        end
        vin[11:0] = 12'h000;
        vin[107:96] = 12'hfff;
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1;
        @(posedge core_clk_in);
        axr(`ACC_CON1_OFS);
        chk("control1 reset", rd[7:0], `ACC_CON1_RST);
        chk("read resp", resp, `ACC_RESP_OKAY);
        axr(4'h2);
        chk("misaligned read resp", resp, `ACC_RESP_SLVERR);
        axr(`ACC_CON2_OFS);
        chk("control2 reset", rd[7:0], `ACC_CON2_RST);
        axr(`ACC_CON3_OFS);
        chk("factory cal", rd[23:0], {factory_gain_in, factory_offset_in});
        axw(`ACC_RES_OFS, 32'h0000_0000);
        chk("result write resp", resp, `ACC_RESP_SLVERR);
        rnd = xs();
        axw(`ACC_CON3_OFS, {8'h01, rnd[23:0]});
        chk("user offset", cal_offset_out, rnd[11:0]);
        chk("user gain", cal_gain_out, rnd[23:12]);
        for (int ch = 0; ch < 10; ch++) begin
            // Last pass uses code 15, which must fall back to the temperature channel
            int ec;
            ec = (ch > 8) ? 8 : ch;
            axw(`ACC_CON2_OFS, 32'h0000_0010 | ((ch > 8) ? 15 : ch));
            wait_irq(400);
            chk("done irq", irq_out, 1);
            chk("channel", channel_select_out, ec);
            axr(`ACC_RES_OFS);
            chk("result", rd[11:0], vin[ec*12 +: 12]);
            axr(`ACC_CON2_OFS);
            chk("done flag", rd[7], 1);
            chk("irq cleared", irq_out, 0);
        end
        axw(`ACC_CON1_OFS, 32'h0000_0000);
        pulse(1, 0);
        axw(`ACC_CON1_OFS, 32'h0000_0001);
        pulse(0, 0);
        pulse(1, 1);
        axw(`ACC_CON1_OFS, 32'h0000_0002);
        pulse(0, 1);
        axw(`ACC_CON2_OFS, 32'h0000_0023);
        wait_irq(400);
        axr(`ACC_CON2_OFS);
        wait_irq(400);
        chk("continuous rerun", irq_out, 1);
        // Stop continuous and drain the conversion under way, else it lands in RAM
        axw(`ACC_CON2_OFS, 32'h0000_0003);
        axr(`ACC_CON2_OFS);
        wait_irq(400);
        axr(`ACC_CON2_OFS);
        axw(`ACC_CON2_OFS, 32'h0000_0045);
        for (i = 0; i < 3000 && far.n_wr < 3; i++) @(posedge core_clk_in);
        axw(`ACC_CON2_OFS, 32'h0000_0000);
        chk("capture word", far.data_log[0], exp_word(4'h5));
        chk("capture word 2", far.data_log[2], exp_word(4'h5));
        chk("capture start", far.addr_log[0], 24'h00_0000);
        chk("capture step", far.addr_log[1], far.addr_log[0] + 24'h00_0002);
        chk("capture step 2", far.addr_log[2], far.addr_log[1] + 24'h00_0002);
        stop_test();
    end
endmodule // acc_tb_top

//--- verilog/acc_defs.vh
// Purpose: constants for the converter control block
// Assumes: AXI4-Lite register bus, 25 MHz core clock
// Notes:   included by acc_top.v and by the testbench
// Contract
// - Eight external inputs plus temperature ninth channel
// - Twelve-bit successive approximation, about five microseconds
// - Single or continuous, software or pin start
// - Second timer trigger starts one conversion
// - DMA mode converts and writes RAM alone
// - Capture address spans sixteen megabytes
// - Factory calibration loaded at power-up
// - Offset and gain registers, software may overwrite
// - Result is straight unsigned binary
// - Three control registers reach everything
// - Pin rising edge holds and starts conversion
// - Pin ignored unless its enable set
// - Timer overflow starts conversion when enabled
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// Register byte offsets
`define ACC_CON1_OFS     4'h0
`define ACC_CON2_OFS     4'h4
`define ACC_CON3_OFS     4'h8
`define ACC_RES_OFS      4'hC
// Reset values
`define ACC_CON1_RST     8'h20
`define ACC_CON2_RST     8'h00
// Control 1 fields
`define ACC_C1_XEN       0
`define ACC_C1_TEN       1
// Control 2 fields
`define ACC_C2_SINGLE    4
`define ACC_C2_CONT      5
`define ACC_C2_DMA       6
`define ACC_C2_DONE      7
// Channel codes
`define ACC_CH_TEMP      4'h8
`define ACC_CH_LAST      4'h8
// Timing
`define ACC_CONV_NS      5000
`define ACC_CLK_MHZ      25
`define ACC_RES_BITS     12
`define ACC_ADDR_BITS    24
`define ACC_STEP_W       4
// AXI responses
`define ACC_RESP_OKAY    2'b00
`define ACC_RESP_SLVERR  2'b10
`endif

//--- verilog/acc_top.v
// Purpose: converter control: triggers, SAR sequence, calibration, DMA, regs
// Assumes: comparator from analog front end, RAM write port with ready
// Notes:   registers: 0 control1, 4 control2, 8 control3/cal, C result
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_top (
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire [3:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [3:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire        convert_start_pin_n_in,
    input  wire        timer2_overflow_in,
    input  wire [11:0] factory_offset_in,
    input  wire [11:0] factory_gain_in,
    input  wire        comparator_in,
    output reg  [3:0]  channel_select_out,
    output reg         track_hold_out,
    output reg  [11:0] dac_code_out,
    output reg  [11:0] cal_offset_out,
    output reg  [11:0] cal_gain_out,
    output reg  [23:0] dma_addr_out,
    output reg  [15:0] dma_data_out,
    output reg         dma_wr_out,
    input  wire        dma_ready_in,
    output wire        irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // Timing derived from the conversion time, rounded down
    localparam integer CONV_CYC   = (`ACC_CONV_NS * `ACC_CLK_MHZ) / 1000;
    localparam integer BIT_CYC_I  = CONV_CYC / `ACC_RES_BITS;
    localparam [7:0]   BIT_CYC    = BIT_CYC_I[7:0];
    // One-hot states
    localparam [4:0] S_IDLE = 5'b0_0001;
    localparam [4:0] S_CAL  = 5'b0_0010;
    localparam [4:0] S_BITS = 5'b0_0100;
    localparam [4:0] S_DONE = 5'b0_1000;
    localparam [4:0] S_DMA  = 5'b1_0000;

    reg [7:0]  con1_r;
    reg [7:0]  con2_r;
    reg [23:0] dma_end_r;
    reg [11:0] result_r;
    reg [4:0]  state_r;
    reg [7:0]  tick_r;
    reg [3:0]  bit_r;
    reg [11:0] sar_r;
    reg        cont_run_r;
    reg [1:0]  pin_sync_r;
    reg        pin_prev_r;
    reg [1:0]  tmr_sync_r;
    reg        tmr_prev_r;
    reg        done_set;
    reg        mask_r;
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    // Clamp a channel code to the nine legal inputs
    function [3:0] acc_chan;
        input [3:0] c;
        begin
            acc_chan = (c > `ACC_CH_LAST) ? `ACC_CH_TEMP : c;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Trigger sources; pin and timer are synchronised first
    wire pin_rise  = pin_sync_r[1] & ~pin_prev_r;
    wire tmr_rise  = tmr_sync_r[1] & ~tmr_prev_r;
    wire ext_trig  = pin_rise & con1_r[`ACC_C1_XEN];
    wire tmr_trig  = tmr_rise & con1_r[`ACC_C1_TEN];
    wire sw_single = con2_r[`ACC_C2_SINGLE];
    wire start_req = sw_single | ext_trig | tmr_trig | cont_run_r;

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pin_sync_r <= 2'b11;
            pin_prev_r <= 1'b1;
            tmr_sync_r <= 2'b00;
            tmr_prev_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], convert_start_pin_n_in};
            pin_prev_r <= pin_sync_r[1];
            tmr_sync_r <= {tmr_sync_r[0], timer2_overflow_in};
            tmr_prev_r <= tmr_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes: hold address and data until both present
    assign s_axi_awready_out = ~aw_hold_r & ~s_axi_bvalid_out;
    assign s_axi_wready_out  = ~w_hold_r & ~s_axi_bvalid_out;
    assign s_axi_arready_out = ~s_axi_rvalid_out;
    wire       aw_have = aw_hold_r | s_axi_awvalid_in;
    wire       w_have  = w_hold_r | s_axi_wvalid_in;
    wire       do_wr   = aw_have & w_have & ~s_axi_bvalid_out;
    wire [3:0] wa      = aw_hold_r ? aw_addr_r : s_axi_awaddr_in;
    wire [31:0] wd     = w_hold_r ? w_data_r : s_axi_wdata_in;
    wire [3:0] ws      = w_hold_r ? w_strb_r : s_axi_wstrb_in;
    wire       do_rd   = s_axi_arvalid_in & ~s_axi_rvalid_out;
    wire       rd_con2 = do_rd & (s_axi_araddr_in == `ACC_CON2_OFS);
    // Plain write to control2 byte: start bits and mode
    wire       wr_con2 = do_wr & (wa == `ACC_CON2_OFS) & ws[0];

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            aw_hold_r        <= 1'b0;
            w_hold_r         <= 1'b0;
            aw_addr_r        <= 4'h0;
            w_data_r         <= 32'h0000_0000;
            w_strb_r         <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `ACC_RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_hold_r        <= 1'b0;
                w_hold_r         <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (wa == `ACC_RES_OFS || wa[1:0] != 2'b00) ?
                                    `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
            end else begin
                if (s_axi_awvalid_in & s_axi_awready_out) begin
                    aw_hold_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr_in;
                end
                if (s_axi_wvalid_in & s_axi_wready_out) begin
                    w_hold_r <= 1'b1;
                    w_data_r <= s_axi_wdata_in;
                    w_strb_r <= s_axi_wstrb_in;
                end
                if (s_axi_bvalid_out & s_axi_bready_in)
                    s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel; reading control2 clears the sticky done flag
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= `ACC_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= `ACC_RESP_OKAY;
            case (s_axi_araddr_in)
                `ACC_CON1_OFS: s_axi_rdata_out <= {24'h00_0000, con1_r};
                `ACC_CON2_OFS: s_axi_rdata_out <= {24'h00_0000, con2_r};
                `ACC_CON3_OFS: s_axi_rdata_out <= {7'h00, mask_r, cal_gain_out, cal_offset_out};
                `ACC_RES_OFS:  s_axi_rdata_out <= {20'h0_0000, result_r};
                default: begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= `ACC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers and calibration; factory load happens in S_CAL
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            con1_r         <= `ACC_CON1_RST;
            con2_r         <= `ACC_CON2_RST;
            mask_r         <= 1'b0;
            cal_offset_out <= 12'h000;
            cal_gain_out   <= 12'h000;
            dma_end_r      <= 24'h00_0000;
        end else begin
            if (state_r == S_CAL) begin
                cal_offset_out <= factory_offset_in;
                cal_gain_out   <= factory_gain_in;
            end
            if (do_wr) begin
                case (wa)
                    `ACC_CON1_OFS: if (ws[0]) con1_r <= wd[7:0];
                    `ACC_CON2_OFS: if (ws[0]) con2_r[6:0] <= wd[6:0];
                    `ACC_CON3_OFS: begin
                        if (ws[0]) cal_offset_out[7:0] <= wd[7:0];
                        if (ws[1]) cal_offset_out[11:8] <= wd[11:8];
                        if (ws[1]) cal_gain_out[3:0] <= wd[15:12];
                        if (ws[2]) cal_gain_out[11:4] <= wd[23:16];
                        if (ws[3]) mask_r <= wd[24];
                        if (ws[3]) dma_end_r <= {wd[31:25], 17'h1_FFFF};
                    end
                    default: ;
                endcase
            end
            // Single-start bit self-clears once taken
            if (state_r == S_IDLE && sw_single && !wr_con2)
                con2_r[`ACC_C2_SINGLE] <= 1'b0;
            // Done flag: set wins over the read clear
            if (done_set)
                con2_r[`ACC_C2_DONE] <= 1'b1;
            else if (rd_con2)
                con2_r[`ACC_C2_DONE] <= 1'b0;
        end
    end

    assign irq_out = con2_r[`ACC_C2_DONE] & mask_r;

    ////////////////////////////////////////////////////////////////////////
    // SAR sequencer and DMA writer
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r            <= S_CAL;
            tick_r             <= 8'h00;
            bit_r              <= 4'h0;
            sar_r              <= 12'h000;
            result_r           <= 12'h000;
            cont_run_r         <= 1'b0;
            done_set           <= 1'b0;
            track_hold_out     <= 1'b0;
            dac_code_out       <= 12'h000;
            channel_select_out <= 4'h0;
            dma_addr_out       <= 24'h00_0000;
            dma_data_out       <= 16'h0000;
            dma_wr_out         <= 1'b0;
        end else begin
            done_set <= 1'b0;
            cont_run_r <= con2_r[`ACC_C2_CONT] | con2_r[`ACC_C2_DMA];
            case (state_r)
                S_CAL: state_r <= S_IDLE;
                S_IDLE: begin
                    if (!con2_r[`ACC_C2_DMA])
                        dma_addr_out <= 24'h00_0000;
                    if (start_req) begin
                        channel_select_out <= acc_chan(con2_r[3:0]);
                        track_hold_out     <= 1'b1;
                        sar_r              <= 12'h800;
                        dac_code_out       <= 12'h800;
                        bit_r              <= 4'd11;
                        tick_r             <= BIT_CYC;
                        state_r            <= S_BITS;
                    end
                end
                S_BITS: begin
                    // One bit per interval; twelve give about five us
                    if (tick_r != 8'h00) begin
                        tick_r <= tick_r - 8'h01;
                    end else begin
                        tick_r <= BIT_CYC;
                        if (!comparator_in)
                            sar_r[bit_r] <= 1'b0;
                        if (bit_r == 4'd0) begin
                            state_r <= S_DONE;
                        end else begin
                            sar_r[bit_r - 4'd1]        <= 1'b1;
                            dac_code_out               <= (comparator_in ? sar_r : (sar_r & ~(12'h001 << bit_r)))
                                                          | (12'h001 << (bit_r - 4'd1));
                            bit_r                      <= bit_r - 4'd1;
                        end
                    end
                end
                S_DONE: begin
                    track_hold_out <= 1'b0;
                    result_r       <= sar_r;
                    if (con2_r[`ACC_C2_DMA]) begin
                        dma_data_out <= {channel_select_out, sar_r};
                        dma_wr_out   <= 1'b1;
                        state_r      <= S_DMA;
                    end else begin
                        done_set <= 1'b1;
                        state_r  <= S_IDLE;
                    end
                end
                S_DMA: begin
                    // Stall until the RAM port accepts the word
                    if (dma_ready_in) begin
                        dma_wr_out   <= 1'b0;
                        dma_addr_out <= dma_addr_out + 24'h00_0002;
                        if (dma_addr_out >= dma_end_r - 24'h00_0001) begin
                            done_set <= 1'b1;
                            state_r  <= S_IDLE;
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // acc_top
